// >>> hw/e3rad_pkg.sv
/*
 * Constants, register map, field layout and types of the E3 receive
 * alarm detector.
 * Assumes a 32-bit APB slave; register byte address is four times the
 * register index.
 */
package e3rad_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // Register indices
    localparam logic [7:0] IDX_OVH_CFG = 8'h10;
    localparam logic [7:0] IDX_ALM_STAT = 8'h11;
    localparam logic [7:0] IDX_IRQ_ONE = 8'h14;
    localparam logic [7:0] IDX_IRQ_TWO = 8'h15;
    localparam logic [REG_W-1:0] REG_RESET = 8'h00;

    // receive_overhead_config fields
    localparam int CFG_PLD_LSB = 5;
    localparam int CFG_SEL_BIT = 4;

    // receive_alarm_status fields
    localparam int STAT_LOS_BIT = 4;
    localparam int STAT_AIS_BIT = 3;
    localparam int STAT_TMARK_BIT = 1;
    localparam int STAT_FAR_FAIL_BIT = 0;

    // Interrupt status fields
    localparam int IRQ1_LOS_BIT = 1;
    localparam int IRQ1_AIS_BIT = 0;
    localparam int IRQ2_FAR_FAIL_BIT = 3;

    // overhead_status_byte fields
    localparam int OVH_FAR_FAIL_BIT = 7;
    localparam int OVH_BLOCK_ERR_BIT = 6;
    localparam int OVH_PLD_MSB = 5;
    localparam int OVH_PLD_LSB = 3;
    localparam int OVH_TMARK_BIT = 0;

    // Detection counts
    localparam logic [5:0] LOS_ZERO_RUN = 6'h20;
    localparam logic [5:0] LOS_GOOD_RUN = 6'h20;
    localparam logic [5:0] LOS_ZERO_GROUP = 6'h04;
    localparam logic [3:0] AIS_MAX_ZEROS = 4'h7;
    localparam logic [3:0] AIS_ZERO_SAT = 4'h8;
    localparam logic [2:0] AIS_FRAMES = 3'h2;
    localparam logic [2:0] FAR_FRAMES_SHORT = 3'h3;
    localparam logic [2:0] FAR_FRAMES_LONG = 3'h5;

    localparam int ALM_AIS = 0;
    localparam int ALM_FAR = 1;
    localparam int NUM_FRAME_ALARMS = 2;

    typedef enum logic [0:0] {
        E3RAD_CLEAR = 1'b0,
        E3RAD_DECLARED = 1'b1
    } e3rad_alarm_t;

    // Byte address match for a register index
    function automatic logic e3rad_hit(logic [ADDR_W-1:0] addr,
                                       logic [7:0] idx);
        return addr == {2'b00, idx, 2'b00};
    endfunction : e3rad_hit

endpackage : e3rad_pkg

// >>> hw/e3rad_alarm.sv
/*
 * Per-frame alarm with one persistence count, need, for both declare and clear.
 * Assumes strobe is one cycle per frame, with bad valid in that cycle.
 */
`timescale 1ns/1ps
module e3rad_alarm (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic strobe,
    input wire logic bad,
    input wire logic [2:0] need,
    output logic declared,
    output logic change
);
    import e3rad_pkg::*;

    e3rad_alarm_t state;
    e3rad_alarm_t next_state;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic next_change;
    logic evidence;
    logic [2:0] cnt_inc;

    // Counts consecutive frames pointing away from the present state
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_change = 1'b0;
        cnt_inc = cnt + 3'h1;
        evidence = (state == E3RAD_CLEAR) ? bad : ~bad;
        if (strobe) begin
            if (!evidence) begin
                next_cnt = 3'h0;
            end else if (cnt_inc >= need) begin
                next_cnt = 3'h0;
                next_change = 1'b1;
                case (state)
                    E3RAD_CLEAR: begin
                        next_state = E3RAD_DECLARED;
                    end
                    E3RAD_DECLARED: begin
                        next_state = E3RAD_CLEAR;
                    end
                    default: begin
                        next_state = E3RAD_CLEAR;
                    end
                endcase
            end else begin
                next_cnt = cnt_inc;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= E3RAD_CLEAR;
            cnt <= 3'h0;
            change <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            cnt <= next_cnt;
            change <= next_change;
        end
    end

    assign declared = (state == E3RAD_DECLARED);

endmodule : e3rad_alarm

// >>> hw/e3rad_top.sv
/*
 * E3 receive alarm detector: loss of signal, all-ones alarm and far-end
 * receive failure, with status pins and an APB register file.
 * Assumes line bits, frame starts and overhead bytes arrive synchronous
 * to pclk, qualified by their strobes, from the framer and line side.
 */
// Register access over APB is this design's own decision.
// What this block does
// - Declare loss of signal after 32 consecutive zero line bits.
// - Declare loss of signal while the external loss input is high.
// - Signal-absent pin is high while loss of signal is declared.
// - Loss of signal sets alarm status bit 4.
// - Loss-of-signal changes set interrupt status one bit 1.
// - Clear loss of signal after 32 bits without four zeros in a row.
// - On clearing: interrupt again, clear status bit 4, pin low.
// - Declare all-ones alarm after two frames each with seven zeros or fewer.
// - All-ones alarm changes set interrupt status one bit 0.
// - All-ones alarm drives its pin and alarm status bit 3.
// - Clear all-ones alarm after two frames each with eight zeros or more.
// - On clearing: interrupt, pin low, status bit 3 zero.
// - Count consecutive frames whose overhead byte has bit 7 set.
// - Far-end failure after 3 frames, or 5 when config bit 4 set.
// - Overhead byte: failure, block error, payload type, dependent, marker.
// - Far-end failure changes set interrupt status two bit 3.
// - Clear far-end failure after the selected count, interrupt, clear bit 0.
`timescale 1ns/1ps
module e3rad_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic [e3rad_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [e3rad_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [e3rad_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic line_bit_valid,
    input wire logic line_positive_in,
    input wire logic line_negative_in,
    input wire logic external_signal_absent_in,
    input wire logic frame_start,
    input wire logic overhead_byte_valid,
    input wire logic [7:0] overhead_status_byte,
    output logic signal_absent_out,
    output logic all_ones_alarm_out,
    output logic far_fail_status
);
    import e3rad_pkg::*;

    // Line-side loss-of-signal state
    logic [5:0] zero_run;
    logic [5:0] next_zero_run;
    logic [5:0] good_run;
    logic [5:0] next_good_run;
    logic los;
    logic next_los;
    logic los_change;
    logic next_los_change;
    logic zero_bit;

    // Per-frame zero counting
    logic [3:0] frame_zeros;
    logic [3:0] next_frame_zeros;
    logic frame_seen;
    logic next_frame_seen;
    logic frame_low;

    // Overhead byte capture
    logic [2:0] pld_type;
    logic [2:0] next_pld_type;
    logic tmark;
    logic next_tmark;

    // Frame alarms
    logic [NUM_FRAME_ALARMS-1:0] alm_strobe;
    logic [NUM_FRAME_ALARMS-1:0] alm_bad;
    logic [2:0] alm_need [NUM_FRAME_ALARMS];
    logic [NUM_FRAME_ALARMS-1:0] alm_declared;
    logic [NUM_FRAME_ALARMS-1:0] alm_change;

    // Register file
    logic far_fail_count_select;
    logic next_far_fail_count_select;
    logic [REG_W-1:0] irq_one;
    logic [REG_W-1:0] next_irq_one;
    logic [REG_W-1:0] irq_two;
    logic [REG_W-1:0] next_irq_two;
    logic next_pready;
    logic next_pslverr;
    logic [DATA_W-1:0] next_prdata;
    logic next_signal_absent;
    logic next_all_ones;
    logic next_far_fail;
    logic acc;
    logic rd_done;
    logic wr_done;
    logic [REG_W-1:0] rd_val;
    logic mapped;

    assign zero_bit = ~line_positive_in & ~line_negative_in;

    // Loss of signal detection
    always_comb begin
        next_zero_run = zero_run;
        next_good_run = good_run;
        next_los = los;
        if (line_bit_valid) begin
            if (zero_bit) begin
                if (zero_run != LOS_ZERO_RUN) begin
                    next_zero_run = zero_run + 6'h01;
                end
            end else begin
                next_zero_run = 6'h00;
            end
            if (zero_bit && next_zero_run >= LOS_ZERO_GROUP) begin
                next_good_run = 6'h00;
            end else if (good_run != LOS_GOOD_RUN) begin
                next_good_run = good_run + 6'h01;
            end
            if (next_zero_run == LOS_ZERO_RUN) begin
                next_los = 1'b1;
            end else if (next_good_run == LOS_GOOD_RUN) begin
                next_los = 1'b0;
            end
        end
        // External loss also restarts the clean-run count
        if (external_signal_absent_in) begin
            next_los = 1'b1;
            next_good_run = 6'h00;
        end
        next_los_change = next_los != los;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_run <= 6'h00;
            good_run <= 6'h00;
            los <= 1'b0;
            los_change <= 1'b0;
        end else if (clk_en) begin
            zero_run <= next_zero_run;
            good_run <= next_good_run;
            los <= next_los;
            los_change <= next_los_change;
        end
    end

    // Zeros per frame, saturating above the all-ones limit
    assign frame_low = frame_zeros <= AIS_MAX_ZEROS;

    always_comb begin
        next_frame_zeros = frame_zeros;
        next_frame_seen = frame_seen;
        next_pld_type = pld_type;
        next_tmark = tmark;
        if (frame_start) begin
            next_frame_seen = 1'b1;
            next_frame_zeros = {3'h0, line_bit_valid & zero_bit};
        end else if (line_bit_valid && zero_bit
                     && frame_zeros != AIS_ZERO_SAT) begin
            next_frame_zeros = frame_zeros + 4'h1;
        end
        if (overhead_byte_valid) begin
            next_pld_type = overhead_status_byte[OVH_PLD_MSB:OVH_PLD_LSB];
            next_tmark = overhead_status_byte[OVH_TMARK_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_zeros <= 4'h0;
            frame_seen <= 1'b0;
            pld_type <= 3'h0;
            tmark <= 1'b0;
        end else if (clk_en) begin
            frame_zeros <= next_frame_zeros;
            frame_seen <= next_frame_seen;
            pld_type <= next_pld_type;
            tmark <= next_tmark;
        end
    end

    // Frame-based alarms: all-ones and far-end failure
    assign alm_strobe[ALM_AIS] = frame_start & frame_seen;
    assign alm_bad[ALM_AIS] = frame_low;
    assign alm_need[ALM_AIS] = AIS_FRAMES;
    assign alm_strobe[ALM_FAR] = overhead_byte_valid;
    assign alm_bad[ALM_FAR] =
        overhead_status_byte[OVH_FAR_FAIL_BIT];
    assign alm_need[ALM_FAR] = far_fail_count_select ? FAR_FRAMES_LONG
        : FAR_FRAMES_SHORT;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FRAME_ALARMS; gi++) begin : g_alarm
            e3rad_alarm u_alarm (
                .clk(pclk),
                .rst_n(presetn),
                .ce(clk_en),
                .strobe(alm_strobe[gi]),
                .bad(alm_bad[gi]),
                .need(alm_need[gi]),
                .declared(alm_declared[gi]),
                .change(alm_change[gi])
            );
        end
    endgenerate

    // APB slave: ready one cycle into the access phase
    assign acc = psel & penable;
    assign rd_done = acc & pready & ~pwrite;
    assign wr_done = acc & pready & pwrite;
    assign mapped = e3rad_hit(paddr, IDX_OVH_CFG)
                    | e3rad_hit(paddr, IDX_ALM_STAT)
                    | e3rad_hit(paddr, IDX_IRQ_ONE)
                    | e3rad_hit(paddr, IDX_IRQ_TWO);

    // Read-back mux; alarm status bits come from the pin flops, the marker bit from tmark
    always_comb begin
        rd_val = REG_RESET;
        if (e3rad_hit(paddr, IDX_OVH_CFG)) begin
            rd_val[CFG_PLD_LSB +: 3] = pld_type;
            rd_val[CFG_SEL_BIT] = far_fail_count_select;
        end else if (e3rad_hit(paddr, IDX_ALM_STAT)) begin
            rd_val[STAT_LOS_BIT] = signal_absent_out;
            rd_val[STAT_AIS_BIT] = all_ones_alarm_out;
            rd_val[STAT_TMARK_BIT] = tmark;
            rd_val[STAT_FAR_FAIL_BIT] = far_fail_status;
        end else if (e3rad_hit(paddr, IDX_IRQ_ONE)) begin
            rd_val = irq_one;
        end else if (e3rad_hit(paddr, IDX_IRQ_TWO)) begin
            rd_val = irq_two;
        end
    end

    always_comb begin
        next_pready = acc & ~pready;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        next_far_fail_count_select = far_fail_count_select;
        if (acc && !pready) begin
            next_pslverr = ~mapped;
            next_prdata = pwrite ? {DATA_W{1'b0}}
                                 : {{(DATA_W-REG_W){1'b0}}, rd_val};
        end
        if (wr_done && pstrb[0] && e3rad_hit(paddr, IDX_OVH_CFG)) begin
            next_far_fail_count_select = pwdata[CFG_SEL_BIT];
        end
        next_signal_absent = los;
        next_all_ones = alm_declared[ALM_AIS];
        next_far_fail = alm_declared[ALM_FAR];
    end

    // Latched change events; only bits returned by the read are cleared
    always_comb begin
        next_irq_one = irq_one;
        next_irq_two = irq_two;
        if (rd_done && e3rad_hit(paddr, IDX_IRQ_ONE)) begin
            next_irq_one = irq_one & ~prdata[REG_W-1:0];
        end
        if (rd_done && e3rad_hit(paddr, IDX_IRQ_TWO)) begin
            next_irq_two = irq_two & ~prdata[REG_W-1:0];
        end
        if (los_change) begin
            next_irq_one[IRQ1_LOS_BIT] = 1'b1;
        end
        if (alm_change[ALM_AIS]) begin
            next_irq_one[IRQ1_AIS_BIT] = 1'b1;
        end
        if (alm_change[ALM_FAR]) begin
            next_irq_two[IRQ2_FAR_FAIL_BIT] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= {DATA_W{1'b0}};
            far_fail_count_select <= 1'b0;
            irq_one <= REG_RESET;
            irq_two <= REG_RESET;
            signal_absent_out <= 1'b0;
            all_ones_alarm_out <= 1'b0;
            far_fail_status <= 1'b0;
        end else if (clk_en) begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
            far_fail_count_select <= next_far_fail_count_select;
            irq_one <= next_irq_one;
            irq_two <= next_irq_two;
            signal_absent_out <= next_signal_absent;
            all_ones_alarm_out <= next_all_ones;
            far_fail_status <= next_far_fail;
        end
    end

endmodule : e3rad_top

// >>> verif/e3rad_chk.sv
/*
 * Port assertions for the E3 receive alarm detector.
 * Bound to e3rad_top; single clock domain on pclk.
 */
`timescale 1ns/1ps
module e3rad_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [e3rad_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic line_bit_valid,
    input wire logic line_positive_in,
    input wire logic line_negative_in,
    input wire logic external_signal_absent_in,
    input wire logic frame_start,
    input wire logic overhead_byte_valid,
    input wire logic [7:0] overhead_status_byte,
    input wire logic signal_absent_out,
    input wire logic all_ones_alarm_out,
    input wire logic far_fail_status
);
    import e3rad_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after access");
    err_pair_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("prdata upper bytes set");
    ext_loss_a: assert property (
        external_signal_absent_in [*2] |=> signal_absent_out)
        else $error("external loss not shown");
    loss_rise_a: assert property (
        $rose(signal_absent_out) |-> $past(external_signal_absent_in, 2)
        || ($past(line_bit_valid, 2) && !$past(line_positive_in, 2)
        && !$past(line_negative_in, 2)))
        else $error("loss declared without cause");
    loss_fall_a: assert property (
        $fell(signal_absent_out) |-> !$past(external_signal_absent_in, 2))
        else $error("loss cleared under external loss");
    ais_edge_a: assert property (
        $changed(all_ones_alarm_out) |-> $past(frame_start, 2))
        else $error("all-ones change off frame");
    far_rise_a: assert property (
        $rose(far_fail_status) |-> $past(overhead_byte_valid, 2)
        && $past(overhead_status_byte[7], 2))
        else $error("far failure without flagged byte");
    far_fall_a: assert property (
        $fell(far_fail_status) |-> $past(overhead_byte_valid, 2)
        && !$past(overhead_status_byte[7], 2))
        else $error("far failure cleared without clean byte");
endmodule : e3rad_chk

bind e3rad_top e3rad_chk u_chk (.*);

// >>> verif/e3rad_liu_model.sv
/*
 * Line side stand-in: line bits, frame starts, overhead bytes and the
 * external loss level, on command. One line bit per pclk at most.
 */
`timescale 1ns/1ps
module e3rad_liu_model (
    input wire logic pclk,
    output logic line_bit_valid,
    output logic line_positive_in,
    output logic line_negative_in,
    output logic external_signal_absent_in,
    output logic frame_start,
    output logic overhead_byte_valid,
    output logic [7:0] overhead_status_byte
);
    import e3rad_pkg::*;
    localparam int FRAME_BITS = 40;
    logic mark = 1'h0;
    initial begin
        line_bit_valid = 1'h0;
        line_positive_in = 1'h0;
        line_negative_in = 1'h0;
        external_signal_absent_in = 1'h0;
        frame_start = 1'h0;
        overhead_byte_valid = 1'h0;
        overhead_status_byte = 8'h00;
    end
    // Marks alternate between the rails
    task automatic put(input logic b, input logic fs, input logic ov,
                       input logic [7:0] ob);
        @(posedge pclk);
        line_bit_valid <= 1'h1;
        line_positive_in <= b & ~mark;
        line_negative_in <= b & mark;
        frame_start <= fs;
        overhead_byte_valid <= ov;
        overhead_status_byte <= ov ? ob : ~overhead_status_byte;
        if (b) mark = ~mark;
    endtask : put
    // No bit offered: rails turned over so stale values never match
    task automatic idle();
        @(posedge pclk);
        line_bit_valid <= 1'h0;
        frame_start <= 1'h0;
        overhead_byte_valid <= 1'h0;
        line_positive_in <= ~line_positive_in;
        line_negative_in <= ~line_negative_in;
        overhead_status_byte <= ~overhead_status_byte;
    endtask : idle
    task automatic run(input int n, input logic b);
        repeat (n) put(b, 1'h0, 1'h0, 8'h00);
        idle();
    endtask : run
    // Zeros sit on odd bits, never two in a row
    task automatic frames(input int n, input int nz, input logic [7:0] ob);
        repeat (n) for (int i = 0; i < FRAME_BITS; i++)
            put(!(i % 2 == 1 && i < 2 * nz), i == 0, i == 20, ob);
        idle();
    endtask : frames
    task automatic set_ext(input logic v);
        @(posedge pclk);
        external_signal_absent_in <= v;
    endtask : set_ext
endmodule : e3rad_liu_model

// >>> verif/e3rad_top_tb.sv
/*
 * Self-checking bench for the E3 receive alarm detector.
 * Assumes the line-side model and the bound port checker.
 */
`timescale 1ns/1ps
module e3rad_top_tb;
    import e3rad_pkg::*;
    localparam logic [ADDR_W-1:0] A_CFG = {2'h0, IDX_OVH_CFG, 2'h0};
    localparam logic [ADDR_W-1:0] A_STAT = {2'h0, IDX_ALM_STAT, 2'h0};
    localparam logic [ADDR_W-1:0] A_IRQ1 = {2'h0, IDX_IRQ_ONE, 2'h0};
    localparam logic [ADDR_W-1:0] A_IRQ2 = {2'h0, IDX_IRQ_TWO, 2'h0};
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [DATA_W-1:0] pwdata = 32'h0;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, line_bit_valid, line_positive_in;
    logic line_negative_in, external_signal_absent_in, frame_start;
    logic overhead_byte_valid;
    logic [7:0] overhead_status_byte;
    logic signal_absent_out, all_ones_alarm_out, far_fail_status;
    logic tm = 1'h0;
    int err_count = 0;
    int comparisons = 0;

    always #2 pclk = ~pclk;

    e3rad_top dut (.clk_en(1'h1), .pstrb(4'hF), .*);
    e3rad_liu_model lu (.*);

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic [7:0] exp,
                       input logic err);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        chk("prdata", {24'h0, exp}, prdata);
        chk("pslverr", {31'h0, err}, {31'h0, pslverr});
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        apb(1'h0, a, 32'h0, exp, 1'h0);
    endtask : rd

    // Pins in order loss, all-ones, far-end; status mirrors them
    task automatic state(input logic [2:0] p);
        repeat (4) @(negedge pclk);
        chk("pins", {29'h0, p}, {29'h0, signal_absent_out,
            all_ones_alarm_out, far_fail_status});
        rd(A_STAT, {3'h0, p[2:1], 1'h0, tm, p[0]});
    endtask : state

    task automatic finish_test();
        $display("Comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    initial begin
        int n;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        state(3'h0);
        rd(A_IRQ1, 8'h00);
        rd(A_IRQ2, 8'h00);
        apb(1'h0, 12'h100, 32'h0, 8'h00, 1'h1);
        apb(1'h1, A_STAT, 32'hFF, 8'h00, 1'h0);
        lu.run(31, 1'h0);
        state(3'h0);
        lu.run(1, 1'h0);
        state(3'h4);
        rd(A_IRQ1, 8'h02);
        rd(A_IRQ1, 8'h00);
        lu.run(4, 1'h0);
        lu.run(10, 1'h1);
        lu.run(3, 1'h0);
        lu.run(18, 1'h1);
        state(3'h4);
        lu.run(1, 1'h1);
        state(3'h0);
        rd(A_IRQ1, 8'h02);
        lu.set_ext(1'h1);
        state(3'h4);
        rd(A_IRQ1, 8'h02);
        lu.set_ext(1'h0);
        lu.run(31, 1'h1);
        state(3'h4);
        lu.run(1, 1'h1);
        state(3'h0);
        rd(A_IRQ1, 8'h02);
        lu.frames(2, 7, 8'h29);
        tm = 1'h1;
        state(3'h0);
        lu.frames(1, 7, 8'h29);
        state(3'h2);
        rd(A_IRQ1, 8'h01);
        lu.frames(2, 8, 8'h29);
        state(3'h2);
        lu.frames(1, 8, 8'h29);
        state(3'h0);
        rd(A_IRQ1, 8'h01);
        rd(A_CFG, 8'hA0);
        for (int s = 0; s < 2; s++) begin
            n = s ? 5 : 3;
            apb(1'h1, A_CFG, {27'h0, s[0], 4'h0}, 8'h00, 1'h0);
            rd(A_CFG, {3'h5, s[0], 4'h0});
            lu.frames(n - 1, 8, 8'hA9);
            state(3'h0);
            lu.frames(1, 8, 8'hA9);
            state(3'h1);
            rd(A_IRQ2, 8'h08);
            rd(A_IRQ1, 8'h00);
            lu.frames(n - 1, 8, 8'h29);
            state(3'h1);
            lu.frames(1, 8, 8'h29);
            state(3'h0);
            rd(A_IRQ2, 8'h08);
        end
        finish_test();
    end

    initial begin
        #100us;
        err_count++;
        finish_test();
    end
endmodule : e3rad_top_tb
